/* bwt_consts.vh */
// bwt_consts.vh: constants of the basic/watchdog timer block
// Function
// - each overflow of the 8-bit basic counter clocks the 3-bit watchdog counter once.
// - the basic count register is an 8-bit free-running read-only counter that resets to zero.
// - control bits [3:2] pick the tick as clock/2^9 (11b), 2^11 (10b), 2^12 (01b), 2^13 (00b).
// - the basic counter steps once per tick and at 255 flags a pending interrupt and wraps to zero.
// - after reset or a stop release the cpu start is held off until counter bit 4 is 1.
// - the basic counter overflow is offered to other logic as an oscillator-stable indication.
// - writing 1 to control bit [1] clears the basic counter and the bit reads back as 0.
// - writing 1 to control bit [0] clears the watchdog counter and the bit reads back as 0.
// - control field [15:8] equal to 10100101b stops the watchdog; any other value lets it reset.
// - reset loads the control register with zero, so the watchdog counts by default.
`ifndef BWT_CONSTS_VH
`define BWT_CONSTS_VH
// ==========================================================
// register byte addresses (printed offsets are indices)
`define BWT_CTRL_IDX      16'hA002
`define BWT_COUNT_IDX     16'hA007
`define BWT_IRQ_STAT_ADDR 20'h28040
`define BWT_IRQ_MASK_ADDR 20'h28044
`define BWT_ADDR_W        20
// ==========================================================
// control register fields
`define BWT_CTRL_RESET    16'h0000
`define BWT_WD_CLR_BIT    0
`define BWT_BT_CLR_BIT    1
`define BWT_SEL_LSB       2
`define BWT_SEL_MSB       3
`define BWT_KEY_LSB       8
`define BWT_KEY_MSB       15
`define BWT_WD_KEY        8'hA5
`define BWT_CTRL_WMASK    16'hFF0C
// ==========================================================
// prescaler and status layout
`define BWT_PRE_W         13
`define BWT_START_BIT     4
`define BWT_ST_OVF_BIT    0
`define BWT_ST_WDR_BIT    1
`define BWT_ST_W          2
`endif

/* bwt_irq.v */
// bwt_irq.v: sticky event status, mask and level interrupt output
`timescale 1ns/1ps
module bwt_irq #(
   parameter W = 2
) (
   // clock and reset
   input  wire         pclk,
   input  wire         presetn,
   // events and software access
   input  wire [W-1:0] evt,
   input  wire         clr_stat,
   input  wire         mask_we,
   input  wire [W-1:0] mask_wdata,
   // state
   output reg  [W-1:0] stat_r,
   output reg  [W-1:0] mask_r,
   output reg          irq_r
);
   wire [W-1:0] stat_nxt;

   // a new event wins over the clear-on-read of the same cycle
   assign stat_nxt = (clr_stat ? {W{1'b0}} : stat_r) | evt;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         stat_r <= {W{1'b0}};
         mask_r <= {W{1'b0}};
         irq_r  <= 1'b0;
      end else begin
         stat_r <= stat_nxt;
         if (mask_we)
            mask_r <= mask_wdata;
         irq_r  <= |(stat_nxt & (mask_we ? mask_wdata : mask_r));
      end
   end
endmodule // bwt_irq

/* bwt_prescaler.v */
// bwt_prescaler.v: free-running divider that yields the selected basic timer tick
`timescale 1ns/1ps
module bwt_prescaler #(
   parameter PRE_W = 13
) (
   // clock and reset
   input  wire         pclk,
   input  wire         presetn,
   // select and tick
   input  wire [1:0]   sel,
   output reg          tick_r
);
`include "bwt_consts.vh"

   reg  [PRE_W-1:0] div_r;
   reg              hit;

   // ==========================================================
   // tap choice: one tick per 2^9, 2^11, 2^12 or 2^13 clocks
   always @* begin
      case (sel)
         2'h3:    hit = (div_r[8:0]  == 9'h1FF);
         2'h2:    hit = (div_r[10:0] == 11'h7FF);
         2'h1:    hit = (div_r[11:0] == 12'hFFF);
         default: hit = (div_r[12:0] == 13'h1FFF);
      endcase
   end

   // divider never stops, so a select change only shifts the next tick
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_r  <= {PRE_W{1'b0}};
         tick_r <= 1'b0;
      end else begin
         div_r  <= div_r + {{(PRE_W-1){1'b0}}, 1'b1};
         tick_r <= hit;
      end
   end
endmodule // bwt_prescaler

/* bwt_timer.v */
// bwt_timer.v: basic timer with watchdog, apb register slave
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
module bwt_timer (
   // apb clock and reset
   input  wire         pclk,
   input  wire         presetn,
   // apb slave
   input  wire         psel,
   input  wire         penable,
   input  wire         pwrite,
   input  wire [19:0]  paddr,
   input  wire [31:0]  pwdata,
   output reg  [31:0]  prdata,
   output reg          pready,
   output reg          pslverr,
   // system
   input  wire         stop_release,
   output reg          cpu_start_r,
   output reg          osc_stable_r,
   output reg          sys_reset_req_r,
   output reg          irq
);
`include "bwt_consts.vh"

   // ==========================================================
   // declarations
   reg  [15:0] ctrl_r;
   reg  [7:0]  count_r;
   reg  [2:0]  wd_count_r;
   reg         start_wait_r;
   reg         ovf_pulse_r;
   reg         sr_a_r;
   reg         sr_b_r;
   reg         sr_c_r;
   wire        tick;
   wire        acc;
   wire        wr;
   wire        rd;
   wire        hit_ctrl;
   wire        hit_count;
   wire        hit_stat;
   wire        hit_mask;
   wire        bt_clr;
   wire        wd_clr;
   wire        bt_ovf;
   wire        wd_run;
   wire        stop_rise;
   wire [1:0]  stat;
   wire [1:0]  mask;
   wire        irq_w;

   function [19:0] idx2addr;
      input [15:0] idx;
      begin
         idx2addr = {2'b00, idx, 2'b00};
      end
   endfunction

   // ==========================================================
   // apb decode: single-cycle access, pready high only in the access cycle
   assign acc       = psel & penable;
   assign wr        = acc & pwrite;
   assign rd        = acc & ~pwrite;
   assign hit_ctrl  = (paddr == idx2addr(`BWT_CTRL_IDX));
   assign hit_count = (paddr == idx2addr(`BWT_COUNT_IDX));
   assign hit_stat  = (paddr == `BWT_IRQ_STAT_ADDR);
   assign hit_mask  = (paddr == `BWT_IRQ_MASK_ADDR);

   // clear bits are write strobes, never stored, so they read back 0
   assign bt_clr = wr & hit_ctrl & pwdata[`BWT_BT_CLR_BIT];
   assign wd_clr = wr & hit_ctrl & pwdata[`BWT_WD_CLR_BIT];

   // ==========================================================
   // stop release pin: three flops, edge when stage two is set and stage three still clear
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sr_a_r <= 1'b0;
         sr_b_r <= 1'b0;
         sr_c_r <= 1'b0;
      end else begin
         sr_a_r <= stop_release;
         sr_b_r <= sr_a_r;
         sr_c_r <= sr_b_r;
      end
   end
   assign stop_rise = sr_b_r & ~sr_c_r;

   // ==========================================================
   // prescaler
   bwt_prescaler #(
      .PRE_W (`BWT_PRE_W)
   ) u_pre (
      .pclk    (pclk),
      .presetn (presetn),
      .sel     (ctrl_r[`BWT_SEL_MSB:`BWT_SEL_LSB]),
      .tick_r  (tick)
   );

   // overflow is the tick that finds the counter at 255
   assign bt_ovf = tick & (count_r == 8'hFF) & ~bt_clr;
   assign wd_run = (ctrl_r[`BWT_KEY_MSB:`BWT_KEY_LSB] != `BWT_WD_KEY);

   // ==========================================================
   // control register: reset to zero, only select and key stored
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         ctrl_r <= `BWT_CTRL_RESET;
      else if (wr & hit_ctrl)
         ctrl_r <= pwdata[15:0] & `BWT_CTRL_WMASK;
   end

   // ==========================================================
   // basic counter: free-running, clear wins over a tick
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         count_r <= 8'h00;
      else if (bt_clr)
         count_r <= 8'h00;
      else if (tick)
         count_r <= count_r + 8'h01;                             // wraps 255 to 0
   end

   // ==========================================================
   // watchdog counter clocked by basic overflows
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wd_count_r      <= 3'h0;
         sys_reset_req_r <= 1'b0;
      end else begin
         sys_reset_req_r <= 1'b0;
         if (wd_clr)
            wd_count_r <= 3'h0;
         else if (bt_ovf & wd_run) begin
            wd_count_r <= wd_count_r + 3'h1;
            if (wd_count_r == 3'h7)
               sys_reset_req_r <= 1'b1;
         end
      end
   end

   // ==========================================================
   // cpu start gate: reset and stop release re-arm the wait
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         start_wait_r <= 1'b1;
         cpu_start_r  <= 1'b0;
      end else begin
         if (stop_rise) begin
            start_wait_r <= 1'b1;
            cpu_start_r  <= 1'b0;
         end else if (start_wait_r & count_r[`BWT_START_BIT]) begin
            start_wait_r <= 1'b0;
            cpu_start_r  <= 1'b1;
         end
      end
   end

   // overflow offered as a clock-stable indication, held from the first overflow until a stop release
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ovf_pulse_r  <= 1'b0;
         osc_stable_r <= 1'b0;
      end else begin
         ovf_pulse_r  <= bt_ovf;
         if (stop_rise)
            osc_stable_r <= 1'b0;
         else if (bt_ovf)
            osc_stable_r <= 1'b1;
      end
   end

   // ==========================================================
   // interrupt status: overflow and watchdog reset events
   bwt_irq #(
      .W (`BWT_ST_W)
   ) u_irq (
      .pclk       (pclk),
      .presetn    (presetn),
      .evt        ({sys_reset_req_r, ovf_pulse_r}),
      .clr_stat   (rd & hit_stat),
      .mask_we    (wr & hit_mask),
      .mask_wdata (pwdata[1:0]),
      .stat_r     (stat),
      .mask_r     (mask),
      .irq_r      (irq_w)
   );
   always @* irq = irq_w;

   // ==========================================================
   // apb read data and response, registered during setup
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~(hit_ctrl | hit_count | hit_stat | hit_mask);
         if (psel & ~penable & ~pwrite) begin
            if (hit_ctrl)
               prdata <= {16'h0000, ctrl_r};
            else if (hit_count)
               prdata <= {24'h000000, count_r};
            else if (hit_stat)
               prdata <= {30'h00000000, stat};
            else if (hit_mask)
               prdata <= {30'h00000000, mask};
            else
               prdata <= 32'h00000000;
         end
      end
   end
endmodule // bwt_timer

/* bwt_timer_assertions.sv */
// bwt_timer_assertions.sv: port-level checks of the timer register slave
`timescale 1ns/1ps
module bwt_chk (
   // clock and reset
   input wire        pclk,
   input wire        presetn,
   // apb
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [19:0] paddr,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   // system
   input wire        cpu_start_r,
   input wire        sys_reset_req_r,
   input wire        irq
);
   // ==========================================================
   // only four words answer; the rest must be refused
   wire mapped = paddr == 20'h28008 || paddr == 20'h2801C ||
                 paddr == 20'h28040 || paddr == 20'h28044;
   wire rd     = pready && !pwrite;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_first_access: assert property (psel && !penable ##1 psel && penable |-> pready)
      else $error("pready missing in first access cycle");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   a_ready_in_access: assert property (pready |-> psel && penable && $past(psel && !penable))
      else $error("pready outside an access cycle");
   a_err_unmapped: assert property (pready && !mapped |-> pslverr)
      else $error("unmapped access not refused");
   a_no_err_mapped: assert property (pready && mapped |-> !pslverr)
      else $error("mapped access refused");
   a_err_read_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read returns data");
   a_ctrl_strobes_zero: assert property (rd && paddr == 20'h28008 |->
      prdata[1:0] == 2'h0 && prdata[31:16] == 16'h0)
      else $error("control clear strobes read back set");
   a_count_width: assert property (rd && paddr == 20'h2801C |-> prdata[31:8] == 24'h0)
      else $error("count wider than eight bits");
   a_reset_pulse: assert property ($rose(sys_reset_req_r) |=> !sys_reset_req_r)
      else $error("system reset request not a single pulse");
   c_irq: cover property ($rose(irq));
   c_start: cover property ($rose(cpu_start_r));
   c_refused: cover property (pslverr);
endmodule // bwt_chk

bind bwt_timer bwt_chk bwt_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .cpu_start_r(cpu_start_r), .sys_reset_req_r(sys_reset_req_r), .irq(irq));

/* tb_top.sv */
// tb_top.sv: self-checking bench for the basic timer with watchdog
`timescale 1ns/1ps
module tb_top;
   // ==========================================================
   localparam [19:0] CTRL = 20'h28008, CNT = 20'h2801C, STAT = 20'h28040, MSK = 20'h28044;
   localparam [31:0] ALL  = 32'hFFFFFFFF;
   reg         pclk, presetn, psel, penable, pwrite, stop_release;
   reg  [19:0] paddr;
   reg  [31:0] pwdata, d;
   reg  [15:0] rnd = 16'h8295;
   reg  [64:0] note;
   reg  [64:0] exp_q[$];
   wire [31:0] prdata;
   wire        pready, pslverr, cpu_start_r, osc_stable_r, sys_reset_req_r, irq;
   integer     num_errors = 0, checks_done = 0, n, i;

   bwt_timer bwt_timer_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .stop_release(stop_release), .cpu_start_r(cpu_start_r),
      .osc_stable_r(osc_stable_r), .sys_reset_req_r(sys_reset_req_r), .irq(irq));

   // 200 mhz clock
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end

   function [15:0] lfsr(input [15:0] s);
      lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task print_verdict;
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // one apb transfer; the note holds refusal, compare mask and expected data
   task apb(input w, input [19:0] a, input [31:0] dw, e, m, input er);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= dw;
      exp_q.push_back({er, m, e});
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 16);
      if (n >= 16) begin num_errors++; print_verdict; end
      psel <= 1'b0; penable <= 1'b0;
   endtask

   // answer watcher: a slave answer always retires the oldest note
   always @(posedge pclk) if (pready === 1'b1) begin
      note = exp_q.pop_front();
      check("pslverr", pslverr, {31'h0, note[64]});
      check("prdata", prdata & note[63:32], note[31:0] & note[63:32]);
   end

   // main sequence
   initial begin
      presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; stop_release = 0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, CTRL, 0, 0, ALL, 0);
      apb(0, CNT, 0, 0, ALL, 0);
      apb(0, MSK, 0, 0, ALL, 0);
      apb(1, 20'h28000, {16'h0, rnd}, 0, 0, 1);
      apb(0, 20'h28000, 0, 0, ALL, 1);
      check("cpu_start", cpu_start_r, 0);
      for (i = 0; i < 4; i++) begin
         rnd = lfsr(rnd);
         d = {16'h0, rnd[15:4], i[1:0], rnd[1:0]};
         apb(1, CTRL, d, 0, 0, 0);
         apb(0, CTRL, 0, d & 32'hFF0C, ALL, 0);
      end
      apb(1, CNT, {16'h0, rnd}, 0, 0, 0);
      apb(1, CTRL, 32'hA50E, 0, 0, 0);
      apb(0, CNT, 0, 0, ALL, 0);
      // twenty ticks of 512 clocks puts the count in 0x10..0x1F
      repeat (20 * 512) @(posedge pclk);
      check("cpu_start", cpu_start_r, 1);
      apb(0, CNT, 0, 32'h10, 32'hFFFFFFF0, 0);
      apb(1, MSK, 3, 0, 0, 0);
      apb(0, MSK, 0, 3, ALL, 0);
      n = 0;
      while (irq !== 1'b1 && n < 140000) begin @(posedge pclk); n++; end
      check("irq", irq, 1);
      check("osc_stable", osc_stable_r, 1);
      apb(1, MSK, 0, 0, 0, 0);
      repeat (2) @(posedge pclk);
      check("irq_masked", irq, 0);
      apb(0, STAT, 0, 1, ALL, 0);
      apb(1, MSK, 3, 0, 0, 0);
      repeat (2) @(posedge pclk);
      check("irq_cleared", irq, 0);
      apb(1, CTRL, 32'hA50D, 0, 0, 0);
      apb(0, CTRL, 0, 32'hA50C, ALL, 0);
      @(posedge pclk) stop_release <= 1'b1;
      @(posedge pclk) stop_release <= 1'b0;
      repeat (6) @(posedge pclk);
      check("cpu_start_rearm", cpu_start_r, 0);
      check("osc_rearm", osc_stable_r, 0);
      repeat (3) @(posedge pclk);
      check("notes_left", exp_q.size(), 0);
      print_verdict;
   end
endmodule // tb_top
